// [logic/crinit_pkg.sv]
// Constants, register map and helpers for the clock and reset init block.
// Assumes a single AHB-Lite slave and a 100 MHz bus clock.
package crinit_pkg;

  // Bus clock rate and transfer size
  localparam int unsigned CLK_MHZ    = 100;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;

  // Register indices; printed offsets are not all word aligned
  localparam logic [7:0] IDX_SEL_LO  = 8'h03;
  localparam logic [7:0] IDX_SEL_HI  = 8'h04;
  localparam logic [7:0] IDX_STATUS  = 8'h05;
  localparam logic [7:0] IDX_SYNTH   = 8'h06;
  localparam logic [7:0] IDX_MCTL    = 8'h22;
  localparam logic [7:0] ADDR_SEL_LO = IDX_SEL_LO << 2;
  localparam logic [7:0] ADDR_SEL_HI = IDX_SEL_HI << 2;
  localparam logic [7:0] ADDR_STATUS = IDX_STATUS << 2;
  localparam logic [7:0] ADDR_SYNTH  = IDX_SYNTH << 2;
  localparam logic [7:0] ADDR_MCTL   = IDX_MCTL << 2;

  // Field positions
  localparam int unsigned LO_IP_LSB   = 0;
  localparam int unsigned LO_ADC_LSB  = 2;
  localparam int unsigned LO_PIX_LSB  = 4;
  localparam int unsigned HI_MTR_LSB  = 0;
  localparam int unsigned MCTL_RUN    = 1;
  localparam int unsigned SYN_SRC_LSB = 0;
  localparam int unsigned SYN_DSP_LSB = 8;
  localparam int unsigned SYN_DLY_LSB = 16;
  localparam int unsigned SYN_W       = 19;

  // Values after reset
  localparam logic [7:0]       SEL_LO_RST = 8'h00;
  localparam logic [7:0]       SEL_HI_RST = 8'h00;
  localparam logic [7:0]       MCTL_RST   = 8'h00;
  localparam logic [SYN_W-1:0] SYNTH_RST  = 19'h00000;

  // Clock domains
  localparam int unsigned NUM_DOM = 5;
  localparam logic [2:0]  DOM_IP  = 3'h0;
  localparam logic [2:0]  DOM_ADC = 3'h1;
  localparam logic [2:0]  DOM_PIX = 3'h2;
  localparam logic [2:0]  DOM_MIC = 3'h3;
  localparam logic [2:0]  DOM_MTR = 3'h4;

  // Source codes of a domain select field
  localparam logic [1:0] SRC_TIMING = 2'h0;
  localparam logic [1:0] SRC_HALF   = 2'h1;
  localparam logic [1:0] SRC_QUART  = 2'h2;
  localparam logic [1:0] SRC_SYNTH  = 2'h3;

  // Nominal rates in MHz used to judge a selection
  localparam int unsigned TIMING_MHZ = 20;
  localparam int unsigned REF_MHZ    = 200;
  localparam int unsigned SYNTH_MHZ  = 165;
  localparam int unsigned DISP_MHZ   = 135;
  localparam int unsigned MAX_IP_MHZ = 165;
  localparam int unsigned MAX_AD_MHZ = 165;
  localparam int unsigned MAX_PX_MHZ = 135;
  localparam int unsigned MAX_MC_MHZ = 100;
  localparam int unsigned MAX_MT_MHZ = 50;

  // Reset stretch and reference PLL preset
  localparam logic [6:0] STRETCH_CYCLES  = 7'h40;
  localparam logic [7:0] PLL_PRESET_MULT = 8'(REF_MHZ / TIMING_MHZ);

  // Power-up sequence, Gray coded along the path
  typedef enum logic [2:0] {
    ST_DEFAULTS = 3'h0,
    ST_STRETCH  = 3'h1,
    ST_PRESET   = 3'h3,
    ST_LOCK     = 3'h2,
    ST_SWITCH   = 3'h6,
    ST_RUN      = 3'h7
  } crinit_state_e;

  // Rate that a code gives a domain; synth means the domain's own synth
  function automatic int unsigned src_mhz(input logic [2:0] dom,
                                          input logic [1:0] code);
    int unsigned r;
    r = TIMING_MHZ;
    unique case (code)
      SRC_TIMING: r = TIMING_MHZ;
      SRC_HALF:   r = REF_MHZ / 2;
      SRC_QUART:  r = REF_MHZ / 4;
      SRC_SYNTH:  r = (dom == DOM_PIX) ? DISP_MHZ :
                      (dom == DOM_MIC) ? REF_MHZ : SYNTH_MHZ;
    endcase
    return r;
  endfunction

  // True when the code keeps the domain within its ceiling
  function automatic logic sel_legal(input logic [2:0] dom,
                                     input logic [1:0] code);
    int unsigned lim;
    lim = (dom == DOM_IP)  ? MAX_IP_MHZ :
          (dom == DOM_ADC) ? MAX_AD_MHZ :
          (dom == DOM_PIX) ? MAX_PX_MHZ :
          (dom == DOM_MIC) ? MAX_MC_MHZ : MAX_MT_MHZ;
    if (dom == DOM_MTR && code == SRC_SYNTH)
      return 1'b0;
    return src_mhz(dom, code) <= lim;
  endfunction

endpackage

// [logic/crinit_ctrl.sv]
// Clock selection, reset stretch and power-up sequencer with AHB-Lite regs.
// Assumes all inputs synchronous to hclk; clocks appear as one-cycle ticks.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Strap low during reset: internal crystal oscillator stays enabled.
// - Strap high: oscillator off, timing pin routed to clock buffer.
// - All straps are latched as hardware reset is released.
// - Reference PLL runs from the timing clock; its clock counts once locked.
// - Source synth runs on the reference clock, re-phased at each hsync.
// - Display synth steps on reference clock, paced by input domain clock.
// - Reference clock divided by two feeds the micro domain.
// - Reference clock divided by four may drive the timing meter.
// - ADC clock comes from source clock; output copy is delay adjusted.
// - Selections keep input/ADC, micro and pixel domains under ceilings.
// - Timing meter domain never selects a source above 50 MHz.
// - Two select registers choose every domain's source except the micro domain's.
// - Every register returns to its default, zero, at reset.
// - Each domain reset holds for 64 of its own clock ticks.
// - Micro domain runs from the timing clock straight after reset.
// - Reference PLL is preset for about 200 MHz from 20 MHz.
// - Micro domain switches to the strap choice only after PLL lock.
// - Micro leaves reset by autostart strap or control bit one.
module crinit_ctrl (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            clk_en,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic      [31:0]                     hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  input  wire logic                            osc_mode_strap,
  input  wire logic                            micro_autostart_strap,
  input  wire logic                            micro_clk_strap,
  input  wire logic                            timing_tick,
  input  wire logic                            ref_tick,
  input  wire logic                            pll_locked,
  input  wire logic                            hsync_in,
  output logic                                 osc_enable,
  output logic                                 ext_clk_route,
  output logic      [7:0]                      pll_mult,
  output logic                                 pll_preset_load,
  output logic      [crinit_pkg::NUM_DOM-1:0]  dom_tick,
  output logic      [crinit_pkg::NUM_DOM-1:0]  dom_rst_n,
  output logic                                 adc_out_tick,
  output logic                                 micro_rst_n
);
  import crinit_pkg::*;

  crinit_state_e      state;
  crinit_state_e      next_state;
  logic               straps_done;
  logic               strap_auto;
  logic               strap_msel;
  logic [7:0]         sel_lo;
  logic [7:0]         sel_hi;
  logic [7:0]         mctl;
  logic [SYN_W-1:0]   synth;
  logic [1:0]         ref_div;
  logic               hsync_q;
  logic [7:0]         src_acc;
  logic [7:0]         disp_acc;
  logic               disp_pend;
  logic [1:0]         micro_src;
  logic               sw_gap;
  logic [7:0]         adc_sr;
  logic               ap_wr;
  logic [7:0]         ap_addr;
  logic [1:0]         dom_sel [NUM_DOM];
  logic [NUM_DOM-1:0] raw_tick;
  logic [NUM_DOM-1:0] synth_tick;
  logic [NUM_DOM-1:0] stretch_done;

  // Pick one tick from the four sources by a select code
  function automatic logic pick(input logic [1:0] code, input logic t,
                                input logic h, input logic q,
                                input logic s);
    logic r;
    r = 1'b0;
    unique case (code)
      SRC_TIMING: r = t;
      SRC_HALF:   r = h;
      SRC_QUART:  r = q;
      SRC_SYNTH:  r = s;
    endcase
    return r;
  endfunction

  // Keep the old field when the new code would overclock its domain
  function automatic logic [1:0] sel_upd(input logic [2:0] dom,
                                         input logic [1:0] old_v,
                                         input logic [1:0] new_v);
    return sel_legal(dom, new_v) ? new_v : old_v;
  endfunction

  // Straps are caught by the first enabled edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      straps_done   <= 1'b0;
      strap_auto    <= 1'b0;
      strap_msel    <= 1'b0;
      osc_enable    <= 1'b1;    // Crystal must run while reset is held
      ext_clk_route <= 1'b0;
    end else if (clk_en && !straps_done) begin
      straps_done   <= 1'b1;
      strap_auto    <= micro_autostart_strap;
      strap_msel    <= micro_clk_strap;
      osc_enable    <= ~osc_mode_strap;
      ext_clk_route <= osc_mode_strap;
    end
  end

  // Reference clock dividers; PLL ticks are ignored until lock
  wire ref_ok     = ref_tick & pll_locked;
  wire half_tick  = ref_ok & ref_div[0];
  wire quart_tick = ref_ok & (ref_div == 2'h3);

  // Source synth: phase accumulator cleared at each hsync rise
  wire       hsync_rise = hsync_in & ~hsync_q;
  wire [8:0] src_sum    = {1'b0, src_acc} + {1'b0, synth[SYN_SRC_LSB +: 8]};
  wire       src_tick   = ref_ok & src_sum[8];

  // Display synth: input ticks are held until a reference tick takes one
  wire       disp_take = ref_ok & (disp_pend | raw_tick[DOM_IP]);
  wire [8:0] disp_sum  = {1'b0, disp_acc} + {1'b0, synth[SYN_DSP_LSB +: 8]};
  wire       disp_tick = disp_take & disp_sum[8];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_div   <= 2'h0;
      hsync_q   <= 1'b0;
      src_acc   <= 8'h00;
      disp_acc  <= 8'h00;
      disp_pend <= 1'b0;
    end else if (clk_en) begin
      hsync_q   <= hsync_in;
      disp_pend <= ~ref_ok & (disp_pend | raw_tick[DOM_IP]);
      if (ref_ok)
        ref_div <= ref_div + 2'h1;
      if (hsync_rise)
        src_acc <= 8'h00;
      else if (ref_ok)
        src_acc <= src_sum[7:0];
      if (disp_take)
        disp_acc <= disp_sum[7:0];
    end
  end

  // Domain source codes; the micro domain follows the sequencer only
  assign dom_sel[DOM_IP]  = sel_lo[LO_IP_LSB +: 2];
  assign dom_sel[DOM_ADC] = sel_lo[LO_ADC_LSB +: 2];
  assign dom_sel[DOM_PIX] = sel_lo[LO_PIX_LSB +: 2];
  assign dom_sel[DOM_MIC] = micro_src;
  assign dom_sel[DOM_MTR] = sel_hi[HI_MTR_LSB +: 2];
  assign synth_tick = {1'b0, 1'b0, disp_tick, src_tick, src_tick};

  // Per-domain tick select and reset stretch
  for (genvar g = 0; g < NUM_DOM; g++) begin : g_dom
    logic [6:0] cnt;
    wire        sel_t = pick(dom_sel[g], timing_tick, half_tick,
                             quart_tick, synth_tick[g]);
    // Micro ticks stay quiet through the switch gap
    if (g == DOM_MIC) begin : g_mic
      assign raw_tick[g] = sel_t & ~sw_gap;
    end else begin : g_oth
      assign raw_tick[g] = sel_t;
    end
    assign stretch_done[g] = (cnt == STRETCH_CYCLES);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt          <= 7'h00;
        dom_tick[g]  <= 1'b0;
        dom_rst_n[g] <= 1'b0;
      end else if (clk_en) begin
        dom_tick[g]  <= raw_tick[g];
        dom_rst_n[g] <= stretch_done[g];
        if (raw_tick[g] && !stretch_done[g])
          cnt <= cnt + 7'h01;
      end
    end
    AST_STRETCH: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(dom_rst_n[g]) |-> $past(cnt) == STRETCH_CYCLES)
      else $error("domain reset released before 64 ticks");
  end

  // Micro clock switch: gap opens after an old tick, closes on a new one
  wire [1:0] boot_sel = strap_msel ? SRC_TIMING : SRC_HALF;
  wire old_tick = pick(micro_src, timing_tick, half_tick, quart_tick, 1'b0);
  wire new_tick = pick(boot_sel, timing_tick, half_tick, quart_tick, 1'b0);
  wire sw_end   = (state == ST_SWITCH) & sw_gap & new_tick;

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_DEFAULTS: next_state = ST_STRETCH;
      ST_STRETCH:  if (stretch_done[DOM_MIC]) next_state = ST_PRESET;
      ST_PRESET:   next_state = ST_LOCK;
      ST_LOCK:     if (pll_locked) next_state = ST_SWITCH;
      ST_SWITCH:   if (sw_end) next_state = ST_RUN;
      ST_RUN:      next_state = ST_RUN;
      default:     next_state = ST_DEFAULTS;
    endcase
  end

  // Sequencer registers, PLL preset and micro reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state           <= ST_DEFAULTS;
      pll_mult        <= 8'h00;
      pll_preset_load <= 1'b0;
      micro_src       <= SRC_TIMING;
      sw_gap          <= 1'b0;
      micro_rst_n     <= 1'b0;
    end else if (clk_en) begin
      state           <= next_state;
      pll_preset_load <= (state == ST_PRESET);
      micro_rst_n     <= (state == ST_RUN) & stretch_done[DOM_MIC] &
                         (strap_auto | mctl[MCTL_RUN]);
      if (state == ST_PRESET)
        pll_mult <= PLL_PRESET_MULT;
      if (sw_end) begin
        sw_gap    <= 1'b0;
        micro_src <= boot_sel;
      end else if (state == ST_SWITCH && old_tick) begin
        sw_gap    <= 1'b1;
      end
    end
  end

  // ADC output clock: sampling ticks through a selectable delay line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_sr       <= 8'h00;
      adc_out_tick <= 1'b0;
    end else if (clk_en) begin
      adc_sr       <= {adc_sr[6:0], raw_tick[DOM_ADC]};
      adc_out_tick <= adc_sr[synth[SYN_DLY_LSB +: 3]];
    end
  end

  // Bus decode; other sizes are answered OKAY and otherwise ignored
  wire ap_take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
  wire wr_lo   = ap_wr & (ap_addr == ADDR_SEL_LO);
  wire wr_hi   = ap_wr & (ap_addr == ADDR_SEL_HI);
  wire wr_mctl = ap_wr & (ap_addr == ADDR_MCTL);
  wire wr_syn  = ap_wr & (ap_addr == ADDR_SYNTH);

  // Illegal codes leave the field as it was
  wire [7:0] next_sel_lo = wr_lo ? {2'h0,
    sel_upd(DOM_PIX, sel_lo[LO_PIX_LSB +: 2], hwdata[LO_PIX_LSB +: 2]),
    sel_upd(DOM_ADC, sel_lo[LO_ADC_LSB +: 2], hwdata[LO_ADC_LSB +: 2]),
    sel_upd(DOM_IP, sel_lo[LO_IP_LSB +: 2], hwdata[LO_IP_LSB +: 2])}
    : sel_lo;
  wire [7:0] next_sel_hi = wr_hi ? {6'h00,
    sel_upd(DOM_MTR, sel_hi[HI_MTR_LSB +: 2], hwdata[HI_MTR_LSB +: 2])}
    : sel_hi;
  wire [7:0]       next_mctl  = wr_mctl ? hwdata[7:0] : mctl;
  wire [SYN_W-1:0] next_synth = wr_syn ? hwdata[SYN_W-1:0] : synth;

  // Reads see a write that completes in the same edge
  wire [31:0] status_w = {19'h00000, dom_rst_n, micro_rst_n, strap_msel,
                          strap_auto, ext_clk_route, pll_locked, state};
  wire [7:0]  rd_addr  = haddr[7:0];
  wire [31:0] rd_data  =
    (rd_addr == ADDR_SEL_LO) ? {24'h000000, next_sel_lo} :
    (rd_addr == ADDR_SEL_HI) ? {24'h000000, next_sel_hi} :
    (rd_addr == ADDR_MCTL)   ? {24'h000000, next_mctl} :
    (rd_addr == ADDR_SYNTH)  ? {13'h0000, next_synth} :
    (rd_addr == ADDR_STATUS) ? status_w : 32'h00000000;

  // Zero wait-state slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr     <= 1'b0;
      ap_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      sel_lo    <= SEL_LO_RST;
      sel_hi    <= SEL_HI_RST;
      mctl      <= MCTL_RST;
      synth     <= SYNTH_RST;
    end else if (clk_en) begin
      ap_wr     <= ap_take & hwrite;
      ap_addr   <= haddr[7:0];
      sel_lo    <= next_sel_lo;
      sel_hi    <= next_sel_hi;
      mctl      <= next_mctl;
      synth     <= next_synth;
      if (ap_take)
        hrdata <= hwrite ? 32'h00000000 : rd_data;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_preset;
    clk_en && state == ST_PRESET;
  endsequence
  sequence s_loaded;
    pll_preset_load && pll_mult == PLL_PRESET_MULT;
  endsequence

  AST_OSC_MODE: assert property ($rose(straps_done) |->
    osc_enable == !$past(osc_mode_strap) && osc_enable != ext_clk_route)
    else $error("oscillator enable does not follow strap");
  AST_STRAP_HOLD: assert property (straps_done |=>
    $stable(strap_auto) && $stable(ext_clk_route))
    else $error("strap value changed after latch");
  AST_HALF: assert property (half_tick |->
    ref_tick && pll_locked && !quart_tick == (ref_div != 2'h3))
    else $error("half rate tick misplaced");
  AST_QUART: assert property (quart_tick |-> half_tick)
    else $error("quarter tick without half tick");
  AST_SEL_LEGAL: assert property (
    sel_legal(DOM_IP, dom_sel[DOM_IP]) &&
    sel_legal(DOM_PIX, dom_sel[DOM_PIX]) &&
    sel_legal(DOM_MIC, micro_src))
    else $error("domain selected above its ceiling");
  AST_METER: assert property (sel_legal(DOM_MTR, dom_sel[DOM_MTR]))
    else $error("meter domain above 50 MHz");
  AST_MICRO_TIMING: assert property (
    state != ST_RUN |-> micro_src == SRC_TIMING)
    else $error("micro domain left timing clock early");
  AST_PRESET: assert property (s_preset |=> s_loaded)
    else $error("pll preset not loaded");
  AST_LOCK: assert property (
    clk_en && state == ST_LOCK && !pll_locked |=> state == ST_LOCK)
    else $error("switch started before pll lock");
  AST_MICRO_RUN: assert property (micro_rst_n |->
    $past(strap_auto || mctl[MCTL_RUN]) && state == ST_RUN)
    else $error("micro released without permission");
  AST_GAP: assert property (sw_gap && clk_en |=> !dom_tick[DOM_MIC])
    else $error("micro tick during switch gap");

endmodule
`default_nettype wire

// [tb/crinit_osc_model.sv]
// Board model: oscillator ticks, reference PLL lock and incoming hsync.
// Assumes hclk at 100 MHz; the timing tick comes once in five cycles.
`timescale 1ns/100ps
`default_nettype none
module crinit_osc_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic preset_load,
  output logic      timing_tick,
  output logic      ref_tick,
  output logic      pll_locked,
  output logic      hsync_in
);
  logic [2:0] tdiv = 3'h0;
  logic [6:0] line_cnt = 7'h00;
  logic [5:0] lock_cnt;
  logic       armed;
  initial begin
    timing_tick = 1'b0;
    ref_tick = 1'b0;
    hsync_in = 1'b0;
  end
  // Clocks run free, also while reset is held
  always @(posedge hclk) begin
    tdiv <= (tdiv == 3'h4) ? 3'h0 : tdiv + 3'h1;
    timing_tick <= (tdiv == 3'h4);
    ref_tick <= ~ref_tick;
    line_cnt <= line_cnt + 7'h01;
    hsync_in <= line_cnt[6];
  end
  // Lock 40 cycles after preset; reset drops lock, as a real PLL would
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed <= 1'b0;
      lock_cnt <= 6'h00;
      pll_locked <= 1'b0;
    end else begin
      if (preset_load) armed <= 1'b1;
      if (armed && lock_cnt != 6'h28) lock_cnt <= lock_cnt + 6'h01;
      pll_locked <= (lock_cnt == 6'h28);
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench: boot sequence, registers and strap latching.
// Assumes zero-wait AHB-Lite slave; board model supplies clock ticks.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  mismatches++; $display("CHECK FAILED %s expected %0h seen %0h", \
  nm, exp, got); end end
module testbench;
  import crinit_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, osc_strap = 1'b0, auto_strap = 1'b0;
  logic        msel_strap = 1'b0;
  logic        timing_tick, ref_tick, pll_locked, hsync_in, osc_enable;
  logic        ext_clk_route, pll_preset_load, adc_out_tick, micro_rst_n;
  logic [7:0]  pll_mult;
  logic [4:0]  dom_tick, dom_rst_n;
  int          mismatches = 0, checked = 0, cycles = 0, n, c;
  always #5 hclk = ~hclk;
  crinit_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_mode_strap(osc_strap), .micro_autostart_strap(auto_strap),
    .micro_clk_strap(msel_strap), .timing_tick(timing_tick),
    .ref_tick(ref_tick), .pll_locked(pll_locked), .hsync_in(hsync_in),
    .osc_enable(osc_enable), .ext_clk_route(ext_clk_route),
    .pll_mult(pll_mult), .pll_preset_load(pll_preset_load),
    .dom_tick(dom_tick), .dom_rst_n(dom_rst_n),
    .adc_out_tick(adc_out_tick), .micro_rst_n(micro_rst_n));
  crinit_osc_model board (.hclk(hclk), .hresetn(hresetn),
    .preset_load(pll_preset_load), .timing_tick(timing_tick),
    .ref_tick(ref_tick), .pll_locked(pll_locked), .hsync_in(hsync_in));
  // Hang guard: whole run is about a thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One single transfer; address phase held until hready, then data
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic do_reset(input int len);
    hresetn <= 1'b0;
    repeat (len - 1) @(posedge hclk);
    @(negedge hclk);
    `CHK("osc_enable_rst", 1'b1, osc_enable)
    `CHK("micro_rst_rst", 1'b0, micro_rst_n)
    `CHK("dom_rst_rst", 5'h00, dom_rst_n)
    @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // Boot: stretch, preset, lock wait, switch; micro held without strap
  task automatic t_boot();
    n = 0; c = 0;
    @(negedge hclk);
    while (dom_rst_n[DOM_MIC] !== 1'b1) begin
      if (dom_tick[DOM_MIC] === 1'b1) n++;
      c++;
      @(negedge hclk);
    end
    `CHK("micro_stretch", 64, n)
    `CHK("micro_on_timing", 1'b1, (c >= 315 && c <= 330))
    `CHK("osc_enable", 1'b1, osc_enable)
    `CHK("ext_route", 1'b0, ext_clk_route)
    while (pll_preset_load !== 1'b1) @(negedge hclk);
    `CHK("pll_mult", 8'h0a, pll_mult)
    ahb(ADDR_STATUS, 1'b0, 32'h0, rd);
    `CHK("state_lock", 3'h2, rd[2:0])
    while (pll_locked !== 1'b1) @(negedge hclk);
    do ahb(ADDR_STATUS, 1'b0, 32'h0, rd); while (rd[2:0] !== 3'h7);
    `CHK("locked_seen", 1'b1, rd[3])
    repeat (3) @(negedge hclk);
    `CHK("micro_held", 1'b0, micro_rst_n)
    ahb(ADDR_MCTL, 1'b1, 32'h2, rd);
    repeat (3) @(negedge hclk);
    `CHK("micro_run_bit", 1'b1, micro_rst_n)
    mic_gap(c);
    `CHK("micro_half_rate", 4, c)
  endtask
  // Cycles from one micro domain tick to the next, capped at 20
  task automatic mic_gap(output int g);
    while (dom_tick[DOM_MIC] !== 1'b1) @(negedge hclk);
    g = 0;
    do begin
      @(negedge hclk);
      g++;
    end while (dom_tick[DOM_MIC] !== 1'b1 && g < 20);
  endtask
  // Register defaults, select fields, refused codes, unmapped place
  task automatic t_regs();
    logic [7:0] addrs [4];
    addrs = '{ADDR_SEL_LO, ADDR_SEL_HI, ADDR_SYNTH, 8'h40};
    foreach (addrs[i]) begin
      ahb(addrs[i], 1'b0, 32'h0, rd);
      `CHK("reg_default", 32'h0, rd)
    end
    ahb(ADDR_SEL_LO, 1'b1, 32'h3f, rd);
    ahb(ADDR_SEL_LO, 1'b0, 32'h0, rd);
    `CHK("sel_lo", 32'h3f, rd)
    ahb(ADDR_SEL_HI, 1'b1, 32'h3, rd);
    ahb(ADDR_SEL_HI, 1'b0, 32'h0, rd);
    `CHK("meter_synth_refused", 32'h0, rd)
    ahb(ADDR_SEL_HI, 1'b1, 32'h2, rd);
    ahb(ADDR_SEL_HI, 1'b0, 32'h0, rd);
    `CHK("meter_quarter", 32'h2, rd)
    ahb(ADDR_SEL_HI, 1'b1, 32'h1, rd);
    ahb(ADDR_SEL_HI, 1'b0, 32'h0, rd);
    `CHK("meter_half_refused", 32'h2, rd)
    ahb(8'h40, 1'b1, 32'h5a, rd);
    ahb(8'h40, 1'b0, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    `CHK("okay_resp", 1'b0, hresp)
  endtask
  // ADC output copy trails the ADC domain tick by the delay field plus one
  task automatic t_adc();
    ahb(ADDR_SYNTH, 1'b1, 32'h0003_0000, rd);
    ahb(ADDR_SYNTH, 1'b0, 32'h0, rd);
    `CHK("synth_rw", 32'h0003_0000, rd)
    repeat (10) @(negedge hclk);
    while (dom_tick[DOM_ADC] !== 1'b1) @(negedge hclk);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (adc_out_tick !== 1'b1 && n < 20);
    `CHK("adc_delay", 4, n)
  endtask
  // Second reset, held a full microsecond, with all three straps pulled up
  task automatic t_straps();
    osc_strap <= 1'b1;
    auto_strap <= 1'b1;
    msel_strap <= 1'b1;
    do_reset(100);
    repeat (2) @(negedge hclk);
    `CHK("osc_disabled", 1'b0, osc_enable)
    `CHK("ext_route_on", 1'b1, ext_clk_route)
    @(posedge hclk);
    osc_strap <= 1'b0;
    repeat (3) @(negedge hclk);
    `CHK("strap_latched", 1'b1, ext_clk_route)
    ahb(ADDR_SEL_LO, 1'b0, 32'h0, rd);
    `CHK("sel_lo_cleared", 32'h0, rd)
    while (micro_rst_n !== 1'b1) @(negedge hclk);
    ahb(ADDR_STATUS, 1'b0, 32'h0, rd);
    `CHK("auto_start_run", 3'h7, rd[2:0])
    `CHK("clk_strap_seen", 1'b1, rd[6])
    mic_gap(c);
    `CHK("micro_timing_rate", 5, c)
  endtask
  initial begin
    do_reset(3);
    t_boot();
    t_regs();
    t_straps();
    t_adc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
